// file: core/rbl_core.sv
// Purpose: execute control for the refetch barrier and byte loads
// Assumes: register file reads are combinational from the rd_*_data ports
// Notes:   one instruction in flight; issue_ready gates the next
`timescale 1ns/1ns
module rbl_core
    import rbl_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    // issue side
    input  wire logic                issue_valid,
    input  wire logic [INSN_W-1:0]   issue_insn,
    input  wire logic                legacy_mode,
    output logic                     issue_ready,
    output logic                     illegal_insn,
    // register file read
    output logic [RIDX_W-1:0]        rd_a_idx,
    output logic [RIDX_W-1:0]        rd_b_idx,
    input  wire logic [REG_W-1:0]    rd_a_data,
    input  wire logic [REG_W-1:0]    rd_b_data,
    // register file write port 0: target, port 1: base update
    output logic                     wr0_en,
    output logic [RIDX_W-1:0]        wr0_idx,
    output logic [REG_W-1:0]         wr0_data,
    output logic                     wr1_en,
    output logic [RIDX_W-1:0]        wr1_idx,
    output logic [REG_W-1:0]         wr1_data,
    // condition field 0 and exception register write enables
    output logic                     cr0_wr_en,
    output logic                     xer_wr_en,
    // load/store subsystem
    output logic                     mem_req,
    output logic [REG_W-1:0]         mem_addr,
    input  wire logic                mem_ack,
    input  wire logic [BYTE_W-1:0]   mem_byte,
    input  wire logic                mem_align_fault,
    input  wire logic                mem_dsi_fault,
    output logic                     fault_taken,
    // pipeline state
    input  wire logic                older_all_done,
    input  wire logic                older_csync_done,
    input  wire logic                fetch_drained,
    output logic                     fetch_flush,
    output logic [REG_W-1:0]         msr_snapshot,
    input  wire logic [REG_W-1:0]    machine_state_word
);

    ////////////////////////////////////////////////////////////////////////
    // decode
    rbl_dec_if dif ();

    rbl_decode u_dec (
        .insn (issue_insn),
        .d    (dif.dec)
    );

    // index or displacement alone when base field is zero, used by several forms
    function automatic logic [REG_W-1:0] ea_calc(
        input logic [RIDX_W-1:0] base,
        input logic [REG_W-1:0]  base_val,
        input logic [REG_W-1:0]  offs
    );
        ea_calc = (base == '0) ? offs : base_val + offs;
    endfunction : ea_calc

    ////////////////////////////////////////////////////////////////////////
    // state
    rbl_state_e              state_ff,    nxt_state;
    rbl_kind_e               kind_ff,     nxt_kind;
    logic [RIDX_W-1:0]       tgt_ff,      nxt_tgt;
    logic [RIDX_W-1:0]       base_ff,     nxt_base;
    logic [REG_W-1:0]        ea_ff,       nxt_ea;
    logic                    legacy_ff,   nxt_legacy;
    logic                    ready_ff,    nxt_ready;
    logic                    illegal_ff,  nxt_illegal;
    logic                    req_ff,      nxt_req;
    logic                    w0_ff,       nxt_w0;
    logic [REG_W-1:0]        w0d_ff,      nxt_w0d;
    logic                    w1_ff,       nxt_w1;
    logic                    fault_ff,    nxt_fault;
    logic                    flush_ff,    nxt_flush;
    logic [REG_W-1:0]        msr_ff,      nxt_msr;

    logic [REG_W-1:0]        ea_now;
    logic                    take;

    assign rd_a_idx = dif.base;
    assign rd_b_idx = dif.idx;
    assign take     = issue_valid && ready_ff;

    always_comb begin
        unique case (dif.kind)
            RBL_K_LD_XU,
            RBL_K_LD_X:  ea_now = ea_calc(dif.base, rd_a_data, rd_b_data);
            default:     ea_now = ea_calc(dif.base, rd_a_data, dif.disp_ext);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // shared conditions
    logic                    grab;
    logic                    order_met;
    logic                    ack_ok;
    logic                    ack_bad;

    // only the update forms may write the base register back
    function automatic logic has_update(input rbl_kind_e kind);
        has_update = (kind == RBL_K_LD_DU) || (kind == RBL_K_LD_XU);
    endfunction : has_update

    // words are only taken while idle, so one is in flight at most
    assign grab      = take && state_ff == RBL_S_IDLE;
    // legacy form only orders against cache-sync operations
    assign order_met = legacy_ff ? older_csync_done : older_all_done;
    // ack qualified by state so a stray ack while idle is ignored
    assign ack_ok    = state_ff == RBL_S_LOAD && mem_ack && !mem_align_fault && !mem_dsi_fault;
    assign ack_bad   = state_ff == RBL_S_LOAD && mem_ack && (mem_align_fault || mem_dsi_fault);

    ////////////////////////////////////////////////////////////////////////
    // sequence: state, ready and the held request
    always_comb begin
        nxt_state = state_ff;
        nxt_ready = ready_ff;
        nxt_req   = req_ff;
        unique case (state_ff)
            RBL_S_IDLE: begin
                if (grab && dif.kind == RBL_K_BAR) begin
                    nxt_ready = 1'b0;
                    nxt_state = RBL_S_DRAIN;
                end else if (grab && !dif.illegal) begin
                    nxt_ready = 1'b0;
                    nxt_req   = 1'b1;
                    nxt_state = RBL_S_LOAD;
                end
            end
            RBL_S_LOAD: begin
                // request stands until the ack edge
                if (mem_ack) begin
                    nxt_req   = 1'b0;
                    nxt_state = RBL_S_DONE;
                end
            end
            RBL_S_DRAIN: begin
                if (order_met) begin
                    nxt_state = RBL_S_FLUSH;
                end
            end
            RBL_S_FLUSH: begin
                if (fetch_drained) begin
                    nxt_state = RBL_S_DONE;
                end
            end
            RBL_S_DONE: begin
                // one idle cycle lets the writes land before the next take
                nxt_ready = 1'b1;
                nxt_state = RBL_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= RBL_S_IDLE;
            ready_ff <= 1'b1;
            req_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ready_ff <= nxt_ready;
            req_ff   <= nxt_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operands captured at the take
    always_comb begin
        nxt_kind   = kind_ff;
        nxt_tgt    = tgt_ff;
        nxt_base   = base_ff;
        nxt_ea     = ea_ff;
        nxt_legacy = legacy_ff;
        if (grab) begin
            nxt_kind   = dif.kind;
            nxt_tgt    = dif.tgt;
            nxt_base   = dif.base;
            nxt_ea     = ea_now;
            nxt_legacy = legacy_mode;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            kind_ff   <= RBL_K_NONE;
            tgt_ff    <= '0;
            base_ff   <= '0;
            ea_ff     <= '0;
            legacy_ff <= 1'b0;
        end else begin
            kind_ff   <= nxt_kind;
            tgt_ff    <= nxt_tgt;
            base_ff   <= nxt_base;
            ea_ff     <= nxt_ea;
            legacy_ff <= nxt_legacy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // load results: target write, base update, fault and refusal pulses
    always_comb begin
        nxt_illegal = 1'b0;
        nxt_w0      = 1'b0;
        nxt_w0d     = w0d_ff;
        nxt_w1      = 1'b0;
        nxt_fault   = 1'b0;
        if (grab && dif.illegal) begin
            // refused word: pulse only, the unit stays ready
            nxt_illegal = 1'b1;
        end
        if (ack_bad) begin
            // a faulting access writes nothing, base included
            nxt_fault = 1'b1;
        end
        if (ack_ok) begin
            nxt_w0  = 1'b1;
            nxt_w0d = {{(REG_W-BYTE_W){1'b0}}, mem_byte};
            // no update for a zero base or a base that is also the target
            nxt_w1  = has_update(kind_ff) && base_ff != '0 && base_ff != tgt_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            illegal_ff <= 1'b0;
            w0_ff      <= 1'b0;
            w0d_ff     <= '0;
            w1_ff      <= 1'b0;
            fault_ff   <= 1'b0;
        end else begin
            illegal_ff <= nxt_illegal;
            w0_ff      <= nxt_w0;
            w0d_ff     <= nxt_w0d;
            w1_ff      <= nxt_w1;
            fault_ff   <= nxt_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // barrier: flush request and the machine state taken at its start
    always_comb begin
        nxt_flush = 1'b0;
        nxt_msr   = msr_ff;
        if (state_ff == RBL_S_DRAIN && order_met) begin
            nxt_flush = 1'b1;
            nxt_msr   = machine_state_word;
        end else if (state_ff == RBL_S_FLUSH) begin
            // held until the fetch side reports the prefetch gone
            nxt_flush = !fetch_drained;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flush_ff <= 1'b0;
            msr_ff   <= '0;
        end else begin
            flush_ff <= nxt_flush;
            msr_ff   <= nxt_msr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops except the two tied-off enables and the read indices decoded from issue_insn
    assign issue_ready  = ready_ff;
    assign illegal_insn = illegal_ff;
    assign mem_req      = req_ff;
    assign mem_addr     = ea_ff;
    assign wr0_en       = w0_ff;
    assign wr0_idx      = tgt_ff;
    assign wr0_data     = w0d_ff;
    assign wr1_en       = w1_ff;
    assign wr1_idx      = base_ff;
    assign wr1_data     = ea_ff;
    assign fault_taken  = fault_ff;
    assign fetch_flush  = flush_ff;
    assign msr_snapshot = msr_ff;
    // no form here records into either register
    assign cr0_wr_en    = 1'b0;
    assign xer_wr_en    = 1'b0;

endmodule : rbl_core

// file: core/rbl_pkg.sv
// Purpose: shared constants and types for the refetch barrier and byte-load unit
// Assumes: big-endian bit numbering in the instruction word (bit 0 is the msb)
// Notes:   field positions are given as lsb-based slices of a 32-bit word
package rbl_pkg;

    localparam int unsigned INSN_W       = 32;
    localparam int unsigned REG_W        = 32;
    localparam int unsigned RIDX_W       = 5;

    // primary opcode, instruction bits 0-5
    localparam int unsigned OPCD_HI      = 31;
    localparam int unsigned OPCD_LO      = 26;
    // target field, bits 6-10
    localparam int unsigned TGT_HI       = 25;
    localparam int unsigned TGT_LO       = 21;
    // base field, bits 11-15
    localparam int unsigned BASE_HI      = 20;
    localparam int unsigned BASE_LO      = 16;
    // index field, bits 16-20
    localparam int unsigned IDX_HI       = 15;
    localparam int unsigned IDX_LO       = 11;
    // extended opcode, bits 21-30
    localparam int unsigned XO_HI        = 10;
    localparam int unsigned XO_LO        = 1;
    // displacement, bits 16-31
    localparam int unsigned DISP_HI      = 15;
    localparam int unsigned DISP_LO      = 0;

    localparam logic [5:0] OP_BARRIER    = 6'h13;   // 19
    localparam logic [5:0] OP_EXT31      = 6'h1F;   // 31
    localparam logic [5:0] OP_LOAD_D     = 6'h22;   // 34
    localparam logic [5:0] OP_LOAD_DU    = 6'h23;   // 35
    localparam logic [9:0] XO_BARRIER    = 10'h096; // 150
    localparam logic [9:0] XO_LOAD_XU    = 10'h077; // 119
    localparam logic [9:0] XO_LOAD_X     = 10'h057; // 87

    localparam int unsigned BYTE_W       = 8;

    typedef enum logic [2:0] {
        RBL_K_NONE   = 3'h0,
        RBL_K_LD_D   = 3'h1,
        RBL_K_LD_DU  = 3'h2,
        RBL_K_LD_XU  = 3'h3,
        RBL_K_LD_X   = 3'h4,
        RBL_K_BAR    = 3'h5
    } rbl_kind_e;

    typedef enum logic [4:0] {
        RBL_S_IDLE   = 5'b00001,
        RBL_S_LOAD   = 5'b00010,
        RBL_S_DRAIN  = 5'b00100,
        RBL_S_FLUSH  = 5'b01000,
        RBL_S_DONE   = 5'b10000
    } rbl_state_e;

endpackage : rbl_pkg

// file: core/rbl_dec_if.sv
// Purpose: carries decoded fields from the decoder to the execute control
// Assumes: single clock, combinational between the two modules
// Notes:   none
`timescale 1ns/1ns
interface rbl_dec_if;
    import rbl_pkg::*;
    rbl_kind_e              kind;
    logic [RIDX_W-1:0]      tgt;
    logic [RIDX_W-1:0]      base;
    logic [RIDX_W-1:0]      idx;
    logic [REG_W-1:0]       disp_ext;
    logic                   illegal;

    modport dec (output kind, output tgt, output base, output idx,
                 output disp_ext, output illegal);
    modport exe (input kind, input tgt, input base, input idx,
                 input disp_ext, input illegal);
endinterface : rbl_dec_if

// file: core/rbl_decode.sv
// Purpose: combinational decode of the barrier and byte-load forms
// Assumes: instruction word stable while presented
// Notes:   reserved fields are never looked at
`timescale 1ns/1ns
module rbl_decode
    import rbl_pkg::*;
(
    input  wire logic [INSN_W-1:0] insn,
    rbl_dec_if.dec                 d
);
    logic [5:0] opcd;
    logic [9:0] xo;

    assign opcd = insn[OPCD_HI:OPCD_LO];
    assign xo   = insn[XO_HI:XO_LO];

    always_comb begin
        d.kind    = RBL_K_NONE;
        d.illegal = 1'b1;
        // bit 31 and barrier register fields not compared
        if (opcd == OP_BARRIER && xo == XO_BARRIER) begin
            d.kind = RBL_K_BAR;
        end else if (opcd == OP_LOAD_D) begin
            d.kind = RBL_K_LD_D;
        end else if (opcd == OP_LOAD_DU) begin
            d.kind = RBL_K_LD_DU;
        end else if (opcd == OP_EXT31 && xo == XO_LOAD_XU) begin
            d.kind = RBL_K_LD_XU;
        end else if (opcd == OP_EXT31 && xo == XO_LOAD_X) begin
            d.kind = RBL_K_LD_X;
        end
        if (d.kind != RBL_K_NONE) begin
            d.illegal = 1'b0;
        end
    end

    assign d.tgt      = insn[TGT_HI:TGT_LO];
    assign d.base     = insn[BASE_HI:BASE_LO];
    assign d.idx      = insn[IDX_HI:IDX_LO];
    // sign extension of the 16-bit offset
    assign d.disp_ext = {{(REG_W-16){insn[DISP_HI]}}, insn[DISP_HI:DISP_LO]};

endmodule : rbl_decode

// file: tb/rbl_mem_model.sv
// Purpose: memory and fetch stand-in at the far side of the byte-load unit
// Assumes: one request in flight at a time
// Notes:   answers after lat waiting cycles; the byte is the address low byte xor 5a
`timescale 1ns/1ns
module rbl_mem_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic        fetch_flush,
    input  wire logic [3:0]  lat,
    input  wire logic [1:0]  flt,
    output logic             mem_ack,
    output logic [7:0]       mem_byte,
    output logic             mem_align_fault,
    output logic             mem_dsi_fault,
    output logic             fetch_drained
);
    logic [3:0] cnt_ff;
    logic       go;
    assign go = (mem_req || fetch_flush) && !mem_ack && !fetch_drained && cnt_ff >= lat;
    ////////////////////////////////////////
    always_ff @(posedge clk) begin
        // idle byte lane toggles, so a stale byte is never taken for good
        mem_byte        <= (go && mem_req) ? mem_addr[7:0] ^ 8'h5a : ~mem_byte;
        mem_ack         <= rst_n && go && mem_req;
        mem_align_fault <= rst_n && go && mem_req && flt[0];
        mem_dsi_fault   <= rst_n && go && mem_req && flt[1];
        fetch_drained   <= rst_n && go && fetch_flush;
        cnt_ff          <= (!rst_n || go || !mem_req && !fetch_flush) ? 4'h0 : cnt_ff + 4'h1;
    end
endmodule : rbl_mem_model

// file: tb/rbl_core_monitor.sv
// Purpose: port-level checks of the byte-load and barrier unit
// Assumes: one clock, rst_n synchronous and active low
// Notes:   displacement address rebuilt here from the word taken
`timescale 1ns/1ns
module rbl_monitor
    import rbl_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        issue_valid,
    input wire logic [31:0] issue_insn,
    input wire logic        issue_ready,
    input wire logic        illegal_insn,
    input wire logic [31:0] rd_a_data,
    input wire logic        wr0_en,
    input wire logic [31:0] wr0_data,
    input wire logic        wr1_en,
    input wire logic [31:0] wr1_data,
    input wire logic        cr0_wr_en,
    input wire logic        xer_wr_en,
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic [7:0]  mem_byte,
    input wire logic        mem_align_fault,
    input wire logic        mem_dsi_fault,
    input wire logic        fault_taken,
    input wire logic        fetch_drained,
    input wire logic        fetch_flush
);
    logic        is_d;
    logic [31:0] ea_d;
    assign is_d = issue_insn[31:26] == OP_LOAD_D || issue_insn[31:26] == OP_LOAD_DU;
    // zero base field means no base, not register zero
    assign ea_d = (issue_insn[20:16] == 5'h0 ? 32'h0 : rd_a_data)
                  + {{16{issue_insn[15]}}, issue_insn[15:0]};
    ////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_flags; !cr0_wr_en && !xer_wr_en; endproperty
    a_flags: assert property (p_flags) else $error("flag write");
    property p_ea_d; issue_valid && issue_ready && is_d
        |=> mem_req && mem_addr == $past(ea_d); endproperty
    a_ea_d: assert property (p_ea_d) else $error("address");
    property p_zext; mem_ack && !mem_align_fault && !mem_dsi_fault
        |=> wr0_en && wr0_data == {24'h0, $past(mem_byte)}; endproperty
    a_zext: assert property (p_zext) else $error("byte write");
    property p_fault; mem_ack && (mem_align_fault || mem_dsi_fault)
        |=> fault_taken && !wr0_en && !wr1_en; endproperty
    a_fault: assert property (p_fault) else $error("fault write");
    property p_upd; wr1_en |-> wr0_en && wr1_data == $past(mem_addr); endproperty
    a_upd: assert property (p_upd) else $error("update value");
    property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_drain; fetch_flush |=> fetch_flush == !$past(fetch_drained); endproperty
    a_drain: assert property (p_drain) else $error("flush length");
    property p_busy; mem_req || fetch_flush |-> !issue_ready; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
    property p_refuse; illegal_insn |-> issue_ready && !mem_req && !fetch_flush; endproperty
    a_refuse: assert property (p_refuse) else $error("refused word started work");
endmodule : rbl_monitor
bind rbl_core rbl_monitor i_mon (.*);

// file: tb/tb_top.sv
// Purpose: self-checking bench for the barrier and byte-load unit
// Assumes: register file and memory modelled here; inputs change at negedge
// Notes:   a loaded byte is the address low byte xor 5a
`timescale 1ns/1ns
module tb_top;
    import rbl_pkg::*;
    logic        clk, issue_ready, illegal_insn, wr0_en, wr1_en, cr0_wr_en, xer_wr_en;
    logic        mem_req, mem_ack, mem_align_fault, mem_dsi_fault, fault_taken, fetch_drained;
    logic        fetch_flush, rst_n = 1'b0, issue_valid = 1'b0, legacy_mode = 1'b0;
    logic        older_all_done = 1'b1, older_csync_done = 1'b1;
    logic [1:0]  flt = 2'h0;
    logic [3:0]  lat = 4'h0;
    logic [4:0]  rd_a_idx, rd_b_idx, wr0_idx, wr1_idx;
    logic [7:0]  mem_byte;
    logic [31:0] issue_insn = 32'h0, machine_state_word = 32'h0, regs [32];
    logic [31:0] rd_a_data, rd_b_data, wr0_data, wr1_data, mem_addr, msr_snapshot;
    int          miscompares, n_tests, cyc;
    rbl_core      i_dut (.*);
    rbl_mem_model i_mem (.*);
    assign rd_a_data = regs[rd_a_idx];
    assign rd_b_data = regs[rd_b_idx];
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wr0_en) regs[wr0_idx] <= wr0_data;
        if (wr1_en) regs[wr1_idx] <= wr1_data;
        if (cyc == 3000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic wrap_up;
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    task automatic issue(input logic [31:0] w);
        issue_insn  = w;
        issue_valid = 1'b1;
        for (int k = 0; k < 40 && issue_ready !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        issue_valid = 1'b0;
    endtask : issue
    task automatic ld(input logic [31:0] w, input logic [1:0] f);
        logic [31:0] ea;
        logic        up;
        up  = (w[31:26] == OP_LOAD_DU || w[31:26] == OP_EXT31 && w[10:1] == XO_LOAD_XU)
              && w[20:16] != 5'h0
              && w[20:16] != w[25:21];
        flt = f;
        issue(w);
        // registers read after the take, so earlier base updates have landed
        ea  = (w[20:16] == 5'h0) ? 32'h0 : regs[w[20:16]];
        ea  = ea + ((w[31:26] == OP_EXT31) ? regs[w[15:11]] : {{16{w[15]}}, w[15:0]});
        for (int k = 0; k < 40 && wr0_en !== 1'b1 && fault_taken !== 1'b1; k++) @(negedge clk);
        if (f != 2'h0) chk(fault_taken === 1'b1 && !wr0_en, "fault");
        else chk(wr0_en === 1'b1 && wr0_idx === w[25:21], "target");
        if (f == 2'h0) chk(wr0_data === {24'h0, ea[7:0] ^ 8'h5a}, "byte");
        chk(wr1_en === (up & !f) && (!wr1_en || wr1_data === ea), "upd");
        chk(!wr1_en || wr1_idx === w[20:16], "upd reg");
        flt = 2'h0;
    endtask : ld
    task automatic t_disp;
        ld({OP_LOAD_D, 5'd3, 5'd4, 16'hfff0}, 2'h0);
        ld({OP_LOAD_D, 5'd6, 5'd0, 16'h1235}, 2'h0);
    endtask : t_disp
    task automatic t_upd;
        lat = 4'h5;
        ld({OP_LOAD_DU, 5'd7, 5'd8, 16'h0021}, 2'h0);
        ld({OP_LOAD_DU, 5'd9, 5'd9, 16'h8003}, 2'h0);
        ld({OP_LOAD_DU, 5'd7, 5'd8, 16'h0001}, 2'h1);
        ld({OP_LOAD_DU, 5'd7, 5'd8, 16'h0002}, 2'h2);
        lat = 4'h0;
    endtask : t_upd
    task automatic t_idx;
        ld({OP_EXT31, 5'd10, 5'd11, 5'd12, XO_LOAD_XU, 1'b0}, 2'h0);
        ld({OP_EXT31, 5'd10, 5'd0, 5'd12, XO_LOAD_XU, 1'b1}, 2'h0);
        ld({OP_EXT31, 5'd13, 5'd14, 5'd15, XO_LOAD_X, 1'b1}, 2'h0);
        ld({OP_EXT31, 5'd13, 5'd0, 5'd15, XO_LOAD_X, 1'b0}, 2'h0);
    endtask : t_idx
    task automatic t_bar;
        logic seen;
        for (int m = 0; m < 2; m++) begin
            // hold back only the condition this mode has to wait for
            legacy_mode        = m[0];
            older_all_done     = m[0];
            older_csync_done   = !m[0];
            machine_state_word = 32'h0000_8030 ^ m;
            seen               = 1'b0;
            issue({OP_BARRIER, 15'h7fff, XO_BARRIER, 1'b1});
            repeat (5) @(negedge clk);
            chk(fetch_flush === 1'b0 && issue_ready === 1'b0, "early");
            older_all_done   = 1'b1;
            older_csync_done = 1'b1;
            for (int k = 0; k < 40 && issue_ready !== 1'b1; k++) begin
                seen = seen | fetch_flush;
                @(negedge clk);
            end
            chk(seen === 1'b1 && msr_snapshot === machine_state_word, "flush");
        end
    endtask : t_bar
    task automatic t_ill;
        // barrier opcode with a foreign extended code, then an unused primary opcode
        for (int m = 0; m < 2; m++) begin
            issue(m == 0 ? {OP_BARRIER, 15'h0000, 10'h097, 1'b0} : 32'hfc00_0000);
            chk(illegal_insn === 1'b1 && issue_ready === 1'b1 && !mem_req, "refuse");
            @(negedge clk);
            chk(illegal_insn === 1'b0 && !fetch_flush && !mem_req, "pulse");
            chk(cr0_wr_en === 1'b0 && xer_wr_en === 1'b0, "flags");
        end
    endtask : t_ill
    task automatic t_rst;
        // reset in mid-barrier must drop back to idle with nothing pending
        legacy_mode    = 1'b0;
        older_all_done = 1'b0;
        issue({OP_BARRIER, 15'h0000, XO_BARRIER, 1'b0});
        repeat (2) @(negedge clk);
        chk(!fetch_flush && issue_ready === 1'b0, "stall");
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk(issue_ready === 1'b1 && !fetch_flush && !mem_req && !wr0_en, "reset");
        older_all_done = 1'b1;
        rst_n          = 1'b1;
        ld({OP_LOAD_D, 5'd1, 5'd2, 16'h0004}, 2'h0);
    endtask : t_rst
    initial begin
        for (int i = 0; i < 32; i++) regs[i] = 32'h0101_0010 * i + 32'h0000_0777;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_disp();
        t_upd();
        t_idx();
        t_bar();
        t_ill();
        t_rst();
        wrap_up();
    end
endmodule : tb_top
